// ### logic/pil_defines.svh
// register offsets, field positions, reset values and request codes of the paged phy register block
// assumes bit 0 of a register is its msb, so field positions are given as data-bus bit indices
`ifndef PIL_DEFINES_SVH
`define PIL_DEFINES_SVH

// ----------------------------------------------------------------
// base register offsets
// ----------------------------------------------------------------
`define PIL_REG_PWR 4'h4
`define PIL_REG_ACCEL 4'h5
`define PIL_REG_PAGE 4'h7

// ----------------------------------------------------------------
// paged offsets
// ----------------------------------------------------------------
`define PIL_REG_COMPLIANCE 4'h8
`define PIL_REG_MAKER_HI 4'hA
`define PIL_REG_MAKER_MID 4'hB
`define PIL_REG_MAKER_LO 4'hC
`define PIL_REG_PART_HI 4'hD
`define PIL_REG_PART_MID 4'hE
`define PIL_REG_PART_LO 4'hF
`define PIL_REG_SOFT_RESET 4'hE

// ----------------------------------------------------------------
// page codes and fixed values
// ----------------------------------------------------------------
`define PIL_PAGE_ID 3'h1
`define PIL_PAGE_VENDOR 3'h7
`define PIL_PAGE_RESET 3'h0
`define PIL_COMPLIANCE_VALUE 8'h02
`define PIL_PWR_RESET 3'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIL_PWR_LSB 0
`define PIL_PAGE_LSB 5
`define PIL_PORT_LSB 0
`define PIL_ARB_ACCEL_BIT 1
`define PIL_CONCAT_BIT 0
`define PIL_SOFT_RESET_BIT 7

// ----------------------------------------------------------------
// legacy link request codes and body lengths
// ----------------------------------------------------------------
`define PIL_REQ_READ 3'h5
`define PIL_REQ_WRITE 3'h6
`define PIL_REQ_ACCEL 3'h7
`define PIL_LEN_BUS 4'h3
`define PIL_LEN_READ 4'h4
`define PIL_LEN_WRITE 4'hC
`define PIL_LEN_ACCEL 4'h1
`define PIL_LEN_NONE 4'h0
`define PIL_TYPE_BITS 4'h2
`define PIL_SPEED_S400 3'h4

`endif

// ### logic/pil_pkg.sv
// types shared by the paged phy register block and its link request decoder
// assumes pil_defines.svh is seen by the modules that use these types
package pil_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] addr;
    logic [7:0] data;
  } pil_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [2:0] speed;
  } pil_bus_req_type;

  typedef enum logic [3:0] {
    PIL_DEC_IDLE = 4'b0001,
    PIL_DEC_TYPE = 4'b0010,
    PIL_DEC_BODY = 4'b0100,
    PIL_DEC_CHECK = 4'b1000
  } pil_dec_state_type;

endpackage : pil_pkg

// ### logic/pil_strap_latch.sv
// captures the power class straps once after every hard or software reset
// assumes straps are static and synchronous to sys_clk
`timescale 1ns/100ps
`include "pil_defines.svh"

module pil_strap_latch (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic [2:0] power_class_straps,
  output logic strap_load,
  output logic [2:0] strap_value
);

  typedef struct packed {
    logic loaded;
    logic load;
    logic [2:0] value;
  } pil_strap_state_type;

  pil_strap_state_type st;
  pil_strap_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.load = 1'b1;
      next_st.value = power_class_straps;
    end
    if (soft_rst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign strap_load = st.load;
  assign strap_value = st.value;

  strap_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    strap_load |-> strap_value == $past(power_class_straps))
    else $error("strap value not captured");

endmodule : pil_strap_latch

// ### logic/pil_lreq_decoder.sv
// serial link request decoder for the legacy interface mode
// assumes one request bit per sys_clk on lreq_bit, msb first, start bit high
`timescale 1ns/100ps
`include "pil_defines.svh"

module pil_lreq_decoder (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic enable,
  input wire logic lreq_bit,
  output pil_pkg::pil_bus_req_type bus_req,
  output pil_pkg::pil_reg_req_type reg_req,
  output logic null_packet,
  output logic accel_valid,
  output logic accel_on
);

  typedef struct packed {
    pil_pkg::pil_dec_state_type fsm;
    logic [3:0] cnt;
    logic [2:0] kind;
    logic [11:0] shift;
    pil_pkg::pil_bus_req_type bus;
    pil_pkg::pil_reg_req_type reg_out;
    logic null_pkt;
    logic acc_v;
    logic acc_on;
  } pil_dec_reg_type;

  localparam pil_dec_reg_type DEC_RESET = '{fsm: pil_pkg::PIL_DEC_IDLE, default: '0};

  pil_dec_reg_type st;
  pil_dec_reg_type next_st;
  logic [2:0] full_kind;
  logic [3:0] body_len;

  always_comb begin
    full_kind = {st.kind[1:0], lreq_bit};
    case (full_kind)
      `PIL_REQ_READ: body_len = `PIL_LEN_READ;
      `PIL_REQ_WRITE: body_len = `PIL_LEN_WRITE;
      `PIL_REQ_ACCEL: body_len = `PIL_LEN_ACCEL;
      3'h4: body_len = `PIL_LEN_NONE;
      default: body_len = `PIL_LEN_BUS;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.bus.valid = 1'b0;
    next_st.reg_out.valid = 1'b0;
    next_st.null_pkt = 1'b0;
    next_st.acc_v = 1'b0;
    case (st.fsm)
      pil_pkg::PIL_DEC_IDLE: begin
        if (lreq_bit) begin
          next_st.fsm = pil_pkg::PIL_DEC_TYPE;
          next_st.cnt = `PIL_TYPE_BITS;
          next_st.kind = 3'h0;
          next_st.shift = 12'h000;
        end
      end
      pil_pkg::PIL_DEC_TYPE: begin
        next_st.kind = full_kind;
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h0) begin
          next_st.cnt = body_len - 4'h1;
          next_st.fsm = (body_len == `PIL_LEN_NONE) ? pil_pkg::PIL_DEC_CHECK : pil_pkg::PIL_DEC_BODY;
        end
      end
      pil_pkg::PIL_DEC_BODY: begin
        next_st.shift = {st.shift[10:0], lreq_bit};
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h0) begin
          next_st.fsm = pil_pkg::PIL_DEC_CHECK;
        end
      end
      pil_pkg::PIL_DEC_CHECK: begin
        // a 7-bit bus request ends with its stop bit in the third speed position,
        // so a high bit here is already the start of the next request
        case (st.kind)
          `PIL_REQ_READ: begin
            next_st.reg_out = '{valid: 1'b1, write: 1'b0, addr: st.shift[3:0], data: 8'h00};
          end
          `PIL_REQ_WRITE: begin
            next_st.reg_out = '{valid: 1'b1, write: 1'b1, addr: st.shift[11:8], data: st.shift[7:0]};
          end
          `PIL_REQ_ACCEL: begin
            next_st.acc_v = 1'b1;
            next_st.acc_on = st.shift[0];
          end
          3'h4: begin
            next_st.acc_v = 1'b0;
          end
          default: begin
            next_st.bus = '{valid: 1'b1, kind: st.kind, speed: st.shift[2:0]};
            next_st.null_pkt = (st.shift[0] || st.shift[2:0] > `PIL_SPEED_S400);
          end
        endcase
        if (lreq_bit) begin
          next_st.fsm = pil_pkg::PIL_DEC_TYPE;
          next_st.cnt = `PIL_TYPE_BITS;
          next_st.kind = 3'h0;
          next_st.shift = 12'h000;
        end else begin
          next_st.fsm = pil_pkg::PIL_DEC_IDLE;
        end
      end
      default: begin
        next_st = DEC_RESET;
      end
    endcase
    if (soft_rst || !enable) begin
      next_st = DEC_RESET;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= DEC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign bus_req = st.bus;
  assign reg_req = st.reg_out;
  assign null_packet = st.null_pkt;
  assign accel_valid = st.acc_v;
  assign accel_on = st.acc_on;

  null_only_bus_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    null_packet |-> bus_req.valid && (bus_req.speed > `PIL_SPEED_S400 || bus_req.speed[0]))
    else $error("null packet without fast bus request");

  back_to_back_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.fsm == pil_pkg::PIL_DEC_CHECK && lreq_bit && enable && !soft_rst)
      |=> st.fsm == pil_pkg::PIL_DEC_TYPE && st.cnt == `PIL_TYPE_BITS)
    else $error("request after 7-bit request lost");

  short_bus_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.fsm == pil_pkg::PIL_DEC_IDLE && lreq_bit && enable && !soft_rst) ##1 (!lreq_bit && enable && !soft_rst) [*7]
      |=> bus_req.valid && bus_req.kind == 3'h0 && bus_req.speed == 3'h0)
    else $error("bus request not decoded");

endmodule : pil_lreq_decoder

// ### logic/pil_phy_regs.sv
// paged phy registers: identification page, vendor page with software hard reset,
// power class from straps, link interface mode selection and legacy request decoding
// assumes all inputs synchronous to sys_clk; link interface pins are decoded to bits outside
//
// Functional notes
// - page selector value 1 maps identification page onto addresses 8 to 15
// - address 8 on identification page reads fixed compliance level 02h
// - 24-bit maker identifier over three bytes, msb at address 1010b
// - 24-bit part identifier over three bytes, msb at address 1101b
// - page selector value 7 maps vendor page onto addresses 8 to 15
// - writing 1 to vendor address 1110 bit 0 hard-resets the whole phy
// - software hard reset bit always reads back as 0
// - power class straps load the self-id power field after hardware reset
// - a later write to register 4 power class replaces the strapped value
// - the 3-bit power class code is carried unchanged, no code rewritten
// - mode pin high selects the gigabit link interface protocol
// - mode pin low selects the legacy protocol, without isolation method
// - legacy mode decodes both 7-bit and 8-bit bus requests
// - a request right after a 7-bit bus request is decoded too
// - legacy bus request faster than S400 sends a null packet
// - 3-bit page selector in register 7, cleared by hard reset, kept otherwise
`timescale 1ns/100ps
`include "pil_defines.svh"

module pil_phy_regs #(
  parameter logic [23:0] MAKER_ID = 24'h5A5A5A, // value is arbitrary
  parameter logic [23:0] PART_ID = 24'hA5A5A5 // value is arbitrary
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic interface_mode_pin,
  input wire logic [2:0] power_class_straps,
  input wire logic lreq_bit,
  input pil_pkg::pil_reg_req_type host_req,
  output logic [7:0] reg_rdata,
  output logic [3:0] reg_raddr,
  output logic reg_rvalid,
  output logic [2:0] self_id_pwr,
  output logic arb_accel_enable,
  output logic multispeed_concat_enable,
  output logic [2:0] page_select,
  output logic link_mode_modern,
  output logic phy_hard_reset,
  output pil_pkg::pil_bus_req_type bus_req,
  output logic null_packet,
  output logic accel_valid,
  output logic accel_on
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pwr;
    logic accel_en;
    logic concat_en;
    logic [2:0] page;
    logic [3:0] port;
    logic modern;
    logic soft_rst;
    logic rvalid;
    logic [3:0] raddr;
    logic [7:0] rdata;
  } pil_regs_state_type;

  localparam pil_regs_state_type REGS_RESET = '0;

  pil_regs_state_type st;
  pil_regs_state_type next_st;
  pil_pkg::pil_reg_req_type acc;
  pil_pkg::pil_reg_req_type dec_req;
  logic strap_load;
  logic [2:0] strap_value;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  pil_strap_latch u_strap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .soft_rst(st.soft_rst),
    .power_class_straps(power_class_straps),
    .strap_load(strap_load),
    .strap_value(strap_value)
  );

  // only the plain legacy link protocol is decoded; there is no isolation variant
  pil_lreq_decoder u_dec (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .soft_rst(st.soft_rst),
    .enable(!st.modern),
    .lreq_bit(lreq_bit),
    .bus_req(bus_req),
    .reg_req(dec_req),
    .null_packet(null_packet),
    .accel_valid(accel_valid),
    .accel_on(accel_on)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [3:0] addr, input pil_regs_state_type s);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      `PIL_REG_PWR: d[`PIL_PWR_LSB +: 3] = s.pwr;
      `PIL_REG_ACCEL: begin
        d[`PIL_ARB_ACCEL_BIT] = s.accel_en;
        d[`PIL_CONCAT_BIT] = s.concat_en;
      end
      `PIL_REG_PAGE: begin
        d[`PIL_PAGE_LSB +: 3] = s.page;
        d[`PIL_PORT_LSB +: 4] = s.port;
      end
      default: d = 8'h00;
    endcase
    if (addr[3] && s.page == `PIL_PAGE_ID) begin
      case (addr)
        `PIL_REG_COMPLIANCE: d = `PIL_COMPLIANCE_VALUE;
        `PIL_REG_MAKER_HI: d = MAKER_ID[23:16];
        `PIL_REG_MAKER_MID: d = MAKER_ID[15:8];
        `PIL_REG_MAKER_LO: d = MAKER_ID[7:0];
        `PIL_REG_PART_HI: d = PART_ID[23:16];
        `PIL_REG_PART_MID: d = PART_ID[15:8];
        `PIL_REG_PART_LO: d = PART_ID[7:0];
        default: d = 8'h00;
      endcase
    end else if (addr[3]) begin
      // vendor page holds only the self-clearing reset bit, so it reads all zero
      d = 8'h00;
    end
    return d;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    acc = st.modern ? host_req : dec_req;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.soft_rst = 1'b0;
    next_st.modern = interface_mode_pin;
    if (strap_load) begin
      next_st.pwr = strap_value;
    end
    if (acc.valid && acc.write) begin
      case (acc.addr)
        `PIL_REG_PWR: next_st.pwr = acc.data[`PIL_PWR_LSB +: 3];
        `PIL_REG_ACCEL: begin
          next_st.accel_en = acc.data[`PIL_ARB_ACCEL_BIT];
          next_st.concat_en = acc.data[`PIL_CONCAT_BIT];
        end
        `PIL_REG_PAGE: begin
          next_st.page = acc.data[`PIL_PAGE_LSB +: 3];
          next_st.port = acc.data[`PIL_PORT_LSB +: 4];
        end
        `PIL_REG_SOFT_RESET: begin
          if (st.page == `PIL_PAGE_VENDOR) begin
            next_st.soft_rst = acc.data[`PIL_SOFT_RESET_BIT];
          end
        end
        default: next_st.soft_rst = 1'b0;
      endcase
    end else if (acc.valid) begin
      next_st.rvalid = 1'b1;
      next_st.raddr = acc.addr;
      next_st.rdata = read_mux(acc.addr, st);
    end
    if (st.soft_rst) begin
      // like the reset pin: everything back to reset values except the mode bit, which takes interface_mode_pin at once
      next_st = REGS_RESET;
      next_st.modern = interface_mode_pin;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= REGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign reg_raddr = st.raddr;
  assign reg_rvalid = st.rvalid;
  assign self_id_pwr = st.pwr;
  assign arb_accel_enable = st.accel_en;
  assign multispeed_concat_enable = st.concat_en;
  assign page_select = st.page;
  assign link_mode_modern = st.modern;
  assign phy_hard_reset = st.soft_rst;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic rd_ok;
  assign rd_ok = acc.valid && !acc.write && !st.soft_rst;

  compliance_read_a: assert property (rd_ok && acc.addr == `PIL_REG_COMPLIANCE && st.page == `PIL_PAGE_ID
    |=> reg_rvalid && reg_rdata == 8'h02 && reg_raddr == 4'h8)
    else $error("compliance level wrong");

  maker_high_a: assert property (rd_ok && acc.addr == 4'hA && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == MAKER_ID[23:16])
    else $error("maker id high byte wrong");

  part_high_a: assert property (rd_ok && acc.addr == 4'hD && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == PART_ID[23:16])
    else $error("part id high byte wrong");

  id_page_map_a: assert property (rd_ok && acc.addr == 4'hF && st.page == 3'h1
    |=> reg_rdata == PART_ID[7:0])
    else $error("id page not mapped");

  reset_bit_read_a: assert property (rd_ok && acc.addr == 4'hE && st.page == 3'h7
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("reset bit not read as zero");

  soft_reset_a: assert property (acc.valid && acc.write && acc.addr == 4'hE && st.page == 3'h7
    && acc.data[7] && !st.soft_rst |=> phy_hard_reset ##1 (page_select == 3'h0 && self_id_pwr == 3'h0
    && !arb_accel_enable && !multispeed_concat_enable))
    else $error("software hard reset missing");

  pwr_write_a: assert property (acc.valid && acc.write && acc.addr == 4'h4 && !st.soft_rst
    |=> self_id_pwr == $past(acc.data[2:0]))
    else $error("power class write lost");

  page_kept_a: assert property (!(acc.valid && acc.write && acc.addr == 4'h7) && !st.soft_rst
    |=> $stable(page_select))
    else $error("page select changed without write");

  id_write_a: assert property (acc.valid && acc.write && acc.addr[3] && st.page == 3'h1 && !st.soft_rst
    |=> $stable(page_select) && !phy_hard_reset && !reg_rvalid)
    else $error("id page write had an effect");

  mode_follow_a: assert property (interface_mode_pin && !st.soft_rst [*2] |-> link_mode_modern)
    else $error("interface mode not followed");

  maker_mid_a: assert property (rd_ok && acc.addr == 4'hB && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == MAKER_ID[15:8])
    else $error("maker id middle byte wrong");

  maker_low_a: assert property (rd_ok && acc.addr == 4'hC && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == MAKER_ID[7:0])
    else $error("maker id low byte wrong");

  part_mid_a: assert property (rd_ok && acc.addr == 4'hE && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == PART_ID[15:8])
    else $error("part id middle byte wrong");

  id_reserved_a: assert property (rd_ok && acc.addr == 4'h9 && st.page == 3'h1
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("reserved id location not zero");

  vendor_zero_a: assert property (rd_ok && acc.addr[3] && st.page == 3'h7
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("vendor page location not zero");

  read_addr_a: assert property (rd_ok
    |=> reg_rvalid && reg_raddr == $past(acc.addr))
    else $error("read answer address wrong");

  accel_write_a: assert property (acc.valid && acc.write && acc.addr == 4'h5 && !st.soft_rst
    |=> arb_accel_enable == $past(acc.data[1]))
    else $error("arbitration acceleration write lost");

  concat_write_a: assert property (acc.valid && acc.write && acc.addr == 4'h5 && !st.soft_rst
    |=> multispeed_concat_enable == $past(acc.data[0]))
    else $error("concatenation enable write lost");

  legacy_ignore_a: assert property (!link_mode_modern && host_req.valid && !dec_req.valid
    && !strap_load && !st.soft_rst |=> !reg_rvalid && $stable(self_id_pwr) && $stable(page_select))
    else $error("host request acted in legacy mode");

  mode_low_a: assert property ((!interface_mode_pin) [*2] |-> !link_mode_modern)
    else $error("legacy mode not followed");

  strap_apply_a: assert property (strap_load && !(acc.valid && acc.write && acc.addr == 4'h4)
    && !st.soft_rst |=> self_id_pwr == $past(strap_value))
    else $error("strapped power class not applied");

  hard_pulse_a: assert property (phy_hard_reset
    |=> !phy_hard_reset && page_select == 3'h0)
    else $error("software hard reset pulse wrong");

  read_cover_c: cover property (rd_ok && st.page == 3'h1 ##1 reg_rvalid);
  soft_reset_c: cover property (phy_hard_reset ##2 strap_load);
  null_packet_c: cover property (null_packet);
  back_to_back_c: cover property (bus_req.valid ##[1:20] dec_req.valid);

endmodule : pil_phy_regs

// ### verif/pil_link_model.sv
// link-layer controller model for the legacy request line
// assumes the bench calls send from one process; lreq_bit changes on falling edges
`timescale 1ns/100ps

module pil_link_model (
  input wire logic sys_clk,
  output logic lreq_bit
);
  initial lreq_bit = 1'b0;
  // ------------------------------------------------
  // request serialiser
  // ------------------------------------------------
  // msb first, then the line returns low; never asks to toggle acceleration on its own
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge sys_clk) lreq_bit <= v[i];
    end
    @(negedge sys_clk) lreq_bit <= 1'b0;
  endtask : send
endmodule : pil_link_model

// ### verif/tb_pil_phy_regs.sv
// self-checking bench of the paged phy register block
// assumes pil_pkg is compiled first; the link model drives the legacy request line
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end

module tb_pil_phy_regs;
  localparam logic [47:0] IDS = 48'h3C1D96_B47E21; // value is arbitrary
  logic sys_clk, sys_rst, mode, lreq_bit, null_packet, accel_valid, accel_on;
  logic [2:0] straps, self_id_pwr, page_select, exp_pwr, sp, kd;
  logic reg_rvalid, arb_accel_enable, multispeed_concat_enable, link_mode_modern, phy_hard_reset;
  logic [7:0] reg_rdata;
  logic [3:0] reg_raddr;
  logic [11:0] got_rd;
  logic got_null;
  pil_pkg::pil_reg_req_type host_req;
  pil_pkg::pil_bus_req_type bus_req, got_bus;
  int checks = 0, n_fail = 0, n_bus = 0, n_rd = 0, n_hr = 0, n_acc = 0, b0, h0;

  pil_phy_regs #(.MAKER_ID(IDS[47:24]), .PART_ID(IDS[23:0])) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .interface_mode_pin(mode),
    .power_class_straps(straps), .lreq_bit(lreq_bit), .host_req(host_req),
    .reg_rdata(reg_rdata), .reg_raddr(reg_raddr), .reg_rvalid(reg_rvalid),
    .self_id_pwr(self_id_pwr), .arb_accel_enable(arb_accel_enable),
    .multispeed_concat_enable(multispeed_concat_enable), .page_select(page_select),
    .link_mode_modern(link_mode_modern), .phy_hard_reset(phy_hard_reset),
    .bus_req(bus_req), .null_packet(null_packet), .accel_valid(accel_valid), .accel_on(accel_on)
  );
  pil_link_model lnk (.sys_clk(sys_clk), .lreq_bit(lreq_bit));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (bus_req.valid) begin
      got_bus <= bus_req;
      got_null <= null_packet;
      n_bus <= n_bus + 1;
    end
    if (reg_rvalid) begin
      got_rd <= {reg_raddr, reg_rdata};
      n_rd <= n_rd + 1;
    end
    if (phy_hard_reset) n_hr <= n_hr + 1;
    if (accel_valid) n_acc <= n_acc + 1;
  end

  // ------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------
  function automatic logic [7:0] idv(input int a);
    idv = (a == 8) ? 8'h02 : (a >= 10) ? IDS[8 * (15 - a) +: 8] : 8'h00;
  endfunction : idv

  task automatic results();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk) host_req = '{1'b1, w, a, d};
    @(negedge sys_clk) host_req.valid = 1'b0;
  endtask : acc

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    int r0;
    r0 = n_rd;
    acc(1'b0, a, 8'h00);
    @(negedge sys_clk);
    `CHK(n_rd, r0 + 1)
    `CHK(got_rd, {a, e})
  endtask : rd

  task automatic wt(ref int c, input int v);
    for (int i = 0; i < 60 && c != v; i++) @(negedge sys_clk);
    if (c != v) begin
      n_fail++;
      results();
    end
  endtask : wt

  initial begin
    sys_rst = 1'b1;
    mode = 1'b1;
    straps = 3'h5;
    host_req = '0;
    void'($urandom(55438));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(self_id_pwr, 3'h5)
    `CHK(page_select, 3'h0)
    `CHK(link_mode_modern, 1'b1)
    acc(1'b1, 4'h7, 8'h20);
    for (int a = 8; a < 16; a++) rd(a[3:0], idv(a));
    acc(1'b1, 4'h8, 8'hFF);
    acc(1'b1, 4'hC, 8'h00);
    rd(4'h8, 8'h02);
    rd(4'hC, idv(12));
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 4'h4, c[7:0]);
      rd(4'h4, c[7:0]);
      `CHK(self_id_pwr, c[2:0])
    end
    acc(1'b1, 4'h5, 8'h03);
    `CHK({arb_accel_enable, multispeed_concat_enable}, 2'b11)
    acc(1'b1, 4'h5, 8'h00);
    `CHK({arb_accel_enable, multispeed_concat_enable}, 2'b00)
    acc(1'b1, 4'h7, 8'hE0);
    acc(1'b1, 4'h9, 8'hFF);
    acc(1'b1, 4'hE, 8'h7F);
    for (int a = 8; a < 16; a++) rd(a[3:0], 8'h00);
    acc(1'b1, 4'h5, 8'h01);
    straps = 3'($urandom);
    h0 = n_hr;
    acc(1'b1, 4'hE, 8'h80);
    repeat (5) @(negedge sys_clk);
    `CHK(n_hr, h0 + 1)
    `CHK(page_select, 3'h0)
    `CHK(multispeed_concat_enable, 1'b0)
    `CHK(self_id_pwr, straps)
    exp_pwr = straps;
    mode = 1'b0;
    acc(1'b1, 4'h4, 8'h07 ^ {5'h0, exp_pwr});
    `CHK(link_mode_modern, 1'b0)
    `CHK(self_id_pwr, exp_pwr)
    for (int s = 0; s < 8; s++) begin
      sp = s[2:0];
      kd = (s == 0) ? 3'h0 : {1'b0, 2'($urandom)};
      b0 = n_bus;
      lnk.send({24'h0, 1'b1, kd, sp, 1'b0}, 8);
      wt(n_bus, b0 + 1);
      `CHK(got_bus, {1'b1, kd, sp})
      `CHK(got_null, sp > 3'h4 || sp[0])
    end
    b0 = n_rd;
    lnk.send({16'h0, 1'b1, 3'h3, 2'b01, 1'b0, 1'b1, 3'h5, 4'h4, 1'b0}, 16);
    wt(n_rd, b0 + 1);
    `CHK(got_bus, {1'b1, 3'h3, 3'h2})
    `CHK(got_rd, {4'h4, 5'h0, exp_pwr})
    repeat (4) begin
      exp_pwr = 3'($urandom);
      lnk.send({15'h0, 1'b1, 3'h6, 4'h4, 5'h0, exp_pwr, 1'b0}, 17);
      repeat (2) @(negedge sys_clk);
      `CHK(self_id_pwr, exp_pwr)
    end
    b0 = n_acc;
    lnk.send({26'h0, 1'b1, 3'h7, 1'b1, 1'b0}, 6);
    wt(n_acc, b0 + 1);
    `CHK(accel_on, 1'b1)
    results();
  end
endmodule : tb_pil_phy_regs
